// file: design/lcs_map.svh
// Purpose: register offsets, field positions and reset values for the link slot and pulse bank
// Assumes: 5-bit register address inside the control page, 8-bit data
// Notes: definitions only
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH
`define LCS_OFS_B_SEL 5'h19
`define LCS_OFS_C_SEL 5'h1A
`define LCS_OFS_PW1 5'h1B
`define LCS_OFS_PW2 5'h1C
`define LCS_OFS_PW3 5'h1D
`define LCS_EN_BIT 7
`define LCS_CH_HI 4
`define LCS_SIGN_BIT 6
`define LCS_MAG_HI 5
`define LCS_LEVEL_HI 6
`define LCS_OVR_BIT 3
`define LCS_RST_REG 8'h00
`define LCS_LAST_CHAN 5'h17
`define LCS_DEF_LEVEL 7'h40
`define LCS_IDLE_LEVEL 7'h00
`endif

// file: design/lcs_pkg.sv
// Purpose: shared types for the link slot and pulse bank
// Assumes: lcs_map.svh holds all numbers
// Notes: types only
package lcs_pkg;
	typedef logic [7:0] lcs_byte_t;
	typedef logic [4:0] lcs_chan_t;
	typedef logic [6:0] lcs_level_t;
	typedef enum logic [1:0] {
		LCS_PH_IDLE = 2'h0,
		LCS_PH_ONE = 2'h1,
		LCS_PH_TWO = 2'h3,
		LCS_PH_THREE = 2'h2
	} lcs_phase_e;
endpackage

// file: design/lcs_slot_port.sv
// Purpose: attaches one link controller to one payload channel
// Assumes: channel count and bit stream aligned to clk, one bit per cycle when bit_valid
// Notes: transmit bit is substituted; receive bit is taken before the elastic buffer
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_slot_port
	import lcs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire logic enable,
	input wire lcs_chan_t channel_number,
	// Frame timing
	input wire lcs_chan_t frame_channel,
	input wire logic bit_valid,
	// Data
	input wire logic serial_payload_in,
	input wire logic ctrl_tx_bit,
	input wire logic line_rx_bit,
	output logic tx_bit,
	output logic ctrl_rx_bit,
	output logic ctrl_rx_strobe,
	output logic ctrl_tx_strobe
);
	typedef struct packed {
		logic tx_bit;
		logic rx_bit;
		logic rx_stb;
		logic tx_stb;
	} lcs_port_s;
	lcs_port_s st, next_st;
	logic hit;
	// Out-of-range channels never match, so a bad setting detaches the controller
	assign hit = enable && channel_number <= `LCS_LAST_CHAN && frame_channel == channel_number;
	always_comb begin
		next_st = st;
		next_st.rx_stb = 1'b0;
		next_st.tx_stb = 1'b0;
		next_st.tx_bit = (hit && bit_valid) ? ctrl_tx_bit : serial_payload_in;
		if (hit && bit_valid) begin
			next_st.rx_bit = line_rx_bit;
			next_st.rx_stb = 1'b1;
			next_st.tx_stb = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tx_bit = st.tx_bit;
	assign ctrl_rx_bit = st.rx_bit;
	assign ctrl_rx_strobe = st.rx_stb;
	assign ctrl_tx_strobe = st.tx_stb;
endmodule

// file: design/lcs_bank.sv
// Purpose: link controller slot selects and custom transmit pulse levels
// Assumes: microprocessor port already decoded to this page; synchronous inputs
// Notes: reset values are zero; pulse levels reach the driver only while override is set
//
// Behaviour
// - Bit 7 of the controller b select register attaches that controller, clear detaches it.
// - Bit 7 of the controller c select register attaches that controller, clear detaches it.
// - Bits 4 to 0 of the controller b select register pick its frame channel.
// - Bits 4 to 0 of the controller c select register pick its frame channel.
// - Channel 0 is first and 23 the last usable one, and software keeps to that range.
// - On transmit the enabled controller's data replaces the serial payload in its channel.
// - On receive the enabled controller takes its channel from the line ahead of the buffer.
// - Pulse word one bits 6 to 0 set the driver level in the first phase of a mark.
// - Pulse word two bits 6 to 0 set the driver level in the second phase of a mark.
// - Pulse word three bits 6 to 0 set the driver level in the third phase of a mark.
// - The pulse words steer the driver only while the override enable is high.
// - A larger magnitude in bits 5 to 0 gives a larger driven amplitude.
// - Bit 6 of a pulse word is the sign, zero negative and one positive.
// - Bits 5 to 0 are an unsigned magnitude in steps of 0.1 volt.
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_bank
	import lcs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Microprocessor port
	input wire logic reg_cs,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire lcs_byte_t reg_wdata,
	output lcs_byte_t reg_rdata,
	// Override bit held in the pulse enable register elsewhere
	input wire logic pulse_override_enable,
	// Frame timing
	input wire lcs_chan_t frame_channel,
	input wire logic bit_valid,
	input wire logic mark_start,
	// Transmit and receive data
	input wire logic serial_payload_in,
	input wire logic line_rx_bit,
	input wire logic link_controller_b_tx,
	input wire logic link_controller_c_tx,
	output logic line_tx_bit,
	output logic link_controller_b_rx,
	output logic link_controller_b_rx_strobe,
	output logic link_controller_b_tx_strobe,
	output logic link_controller_c_rx,
	output logic link_controller_c_rx_strobe,
	output logic link_controller_c_tx_strobe,
	// Line driver level code
	output lcs_level_t line_driver_outputs,
	output logic pulse_sign,
	output logic [5:0] pulse_magnitude
);
	typedef struct packed {
		lcs_byte_t b_sel;
		lcs_byte_t c_sel;
		lcs_byte_t pw1;
		lcs_byte_t pw2;
		lcs_byte_t pw3;
		lcs_byte_t rdata;
		lcs_phase_e phase;
		lcs_level_t level;
		logic tx;
	} lcs_bank_s;
	lcs_bank_s st, next_st;
	logic b_tx;
	logic b_rx;
	logic b_rs;
	logic b_ts;
	logic c_tx;
	logic c_rx;
	logic c_rs;
	logic c_ts;

	function automatic lcs_level_t level_of(input lcs_byte_t word);
		return word[`LCS_LEVEL_HI:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file and pulse phase sequencer
	always_comb begin
		next_st = st;
		if (reg_cs && reg_wr) begin
			case (reg_addr)
				`LCS_OFS_B_SEL: begin
					next_st.b_sel = reg_wdata;
				end
				`LCS_OFS_C_SEL: begin
					next_st.c_sel = reg_wdata;
				end
				`LCS_OFS_PW1: begin
					next_st.pw1 = reg_wdata;
				end
				`LCS_OFS_PW2: begin
					next_st.pw2 = reg_wdata;
				end
				`LCS_OFS_PW3: begin
					next_st.pw3 = reg_wdata;
				end
				default: begin
					next_st.rdata = st.rdata;
				end
			endcase
		end
		// Read data is registered so the port sees it one edge after the address
		case (reg_addr)
			`LCS_OFS_B_SEL: next_st.rdata = st.b_sel;
			`LCS_OFS_C_SEL: next_st.rdata = st.c_sel;
			`LCS_OFS_PW1: next_st.rdata = st.pw1;
			`LCS_OFS_PW2: next_st.rdata = st.pw2;
			`LCS_OFS_PW3: next_st.rdata = st.pw3;
			default: next_st.rdata = 8'h00;
		endcase
		case (st.phase)
			LCS_PH_IDLE: next_st.phase = mark_start ? LCS_PH_ONE : LCS_PH_IDLE;
			LCS_PH_ONE: next_st.phase = LCS_PH_TWO;
			LCS_PH_TWO: next_st.phase = LCS_PH_THREE;
			LCS_PH_THREE: next_st.phase = mark_start ? LCS_PH_ONE : LCS_PH_IDLE;
			default: next_st.phase = LCS_PH_IDLE;
		endcase
		// Code passes straight through: sign in bit 6, magnitude below, so a bigger magnitude is louder
		case (next_st.phase)
			LCS_PH_ONE: begin
				next_st.level = pulse_override_enable ? level_of(next_st.pw1)
					: `LCS_DEF_LEVEL;
			end
			LCS_PH_TWO: begin
				next_st.level = pulse_override_enable ? level_of(next_st.pw2)
					: `LCS_DEF_LEVEL;
			end
			LCS_PH_THREE: begin
				next_st.level = pulse_override_enable ? level_of(next_st.pw3)
					: `LCS_DEF_LEVEL;
			end
			default: begin
				next_st.level = `LCS_IDLE_LEVEL;
			end
		endcase
		// Controller b wins when both select the same channel
		next_st.tx = b_ts ? b_tx : (c_ts ? c_tx : b_tx);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{b_sel: `LCS_RST_REG, c_sel: `LCS_RST_REG, pw1: `LCS_RST_REG,
				pw2: `LCS_RST_REG, pw3: `LCS_RST_REG, rdata: `LCS_RST_REG,
				phase: LCS_PH_IDLE, level: `LCS_IDLE_LEVEL, tx: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel attachment; controller b has priority on the line transmit bit if both pick one channel, both still receive
	lcs_slot_port u_port_b (
		.clk(clk),
		.rst(rst),
		.enable(st.b_sel[`LCS_EN_BIT]),
		.channel_number(st.b_sel[`LCS_CH_HI:0]),
		.frame_channel(frame_channel),
		.bit_valid(bit_valid),
		.serial_payload_in(serial_payload_in),
		.ctrl_tx_bit(link_controller_b_tx),
		.line_rx_bit(line_rx_bit),
		.tx_bit(b_tx),
		.ctrl_rx_bit(b_rx),
		.ctrl_rx_strobe(b_rs),
		.ctrl_tx_strobe(b_ts)
	);
	lcs_slot_port u_port_c (
		.clk(clk),
		.rst(rst),
		.enable(st.c_sel[`LCS_EN_BIT]),
		.channel_number(st.c_sel[`LCS_CH_HI:0]),
		.frame_channel(frame_channel),
		.bit_valid(bit_valid),
		.serial_payload_in(serial_payload_in),
		.ctrl_tx_bit(link_controller_c_tx),
		.line_rx_bit(line_rx_bit),
		.tx_bit(c_tx),
		.ctrl_rx_bit(c_rx),
		.ctrl_rx_strobe(c_rs),
		.ctrl_tx_strobe(c_ts)
	);
	assign line_tx_bit = st.tx;
	assign link_controller_b_rx = b_rx;
	assign link_controller_b_rx_strobe = b_rs;
	assign link_controller_b_tx_strobe = b_ts;
	assign link_controller_c_rx = c_rx;
	assign link_controller_c_rx_strobe = c_rs;
	assign link_controller_c_tx_strobe = c_ts;
	assign reg_rdata = st.rdata;
	assign line_driver_outputs = st.level;
	assign pulse_sign = st.level[`LCS_SIGN_BIT];
	assign pulse_magnitude = st.level[`LCS_MAG_HI:0];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_wr_readback: assert property (@(posedge clk) disable iff (rst)
		reg_cs && reg_wr && reg_addr == `LCS_OFS_PW1 ##1
		!(reg_cs && reg_wr) && reg_addr == `LCS_OFS_PW1
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("readback mismatch");
	a_ph1_level: assert property (@(posedge clk) disable iff (rst)
		st.phase == LCS_PH_ONE && pulse_override_enable |-> line_driver_outputs == st.pw1[6:0])
		else $error("phase one level wrong");
	a_ph2_level: assert property (@(posedge clk) disable iff (rst)
		st.phase == LCS_PH_TWO && pulse_override_enable |-> line_driver_outputs == st.pw2[6:0])
		else $error("phase two level wrong");
	a_ph3_level: assert property (@(posedge clk) disable iff (rst)
		st.phase == LCS_PH_THREE && pulse_override_enable |-> line_driver_outputs == st.pw3[6:0])
		else $error("phase three level wrong");
	a_default_shape: assert property (@(posedge clk) disable iff (rst)
		st.phase != LCS_PH_IDLE && !pulse_override_enable |-> line_driver_outputs == `LCS_DEF_LEVEL)
		else $error("default shape not used");
	a_b_detached: assert property (@(posedge clk) disable iff (rst)
		!st.b_sel[7] |=> !link_controller_b_rx_strobe) else $error("b strobe while off");
	a_c_detached: assert property (@(posedge clk) disable iff (rst)
		!st.c_sel[7] |=> !link_controller_c_rx_strobe) else $error("c strobe while off");
	a_b_channel: assert property (@(posedge clk) disable iff (rst)
		st.b_sel[7] && bit_valid && frame_channel == st.b_sel[4:0] && st.b_sel[4:0] <= 5'h17
		|=> link_controller_b_rx_strobe && link_controller_b_rx == $past(line_rx_bit))
		else $error("b channel miss");
	a_c_channel: assert property (@(posedge clk) disable iff (rst)
		st.c_sel[7] && bit_valid && frame_channel == st.c_sel[4:0] && st.c_sel[4:0] <= 5'h17
		|=> link_controller_c_rx_strobe && link_controller_c_rx == $past(line_rx_bit))
		else $error("c channel miss");
	a_tx_subst: assert property (@(posedge clk) disable iff (rst)
		st.b_sel[7] && bit_valid && frame_channel == st.b_sel[4:0] && st.b_sel[4:0] <= 5'h17
		|=> ##1 line_tx_bit == $past(link_controller_b_tx, 2)) else $error("tx not substituted");
endmodule

// file: bench/lcs_bank_tb.sv
// Purpose: self-checking bench for the link slot and pulse bank
// Assumes: registered outputs, one cycle per pulse phase; assertions live in the design files
// Notes: table rows for registers and channels, hand tests for reset and marks
`timescale 1ns/1ps
module lcs_bank_tb
	import lcs_pkg::*;
;
	typedef struct {logic [4:0] a; lcs_byte_t d; lcs_byte_t e;} lcs_reg_row_s;
	// Flags: line bit, b tx, c tx, payload, b hit, c hit, expected tx bit
	typedef struct {lcs_byte_t bs; lcs_byte_t cs; lcs_chan_t ch; logic [6:0] f;} lcs_chan_row_s;
	logic clk = 1'h0;
	logic rst, reg_cs, reg_wr, pulse_override_enable, bit_valid, mark_start;
	logic serial_payload_in, line_rx_bit, b_tx, c_tx;
	logic [4:0] reg_addr;
	lcs_byte_t reg_wdata, reg_rdata;
	lcs_chan_t frame_channel;
	logic line_tx_bit, b_rx, b_rxs, b_txs, c_rx, c_rxs, c_txs, sign;
	lcs_level_t level;
	logic [5:0] mag;
	lcs_level_t pw [1:3];
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	// Reserved bits written as zero; unmapped 18 and 1E read back 00
	lcs_reg_row_s regs [7] = '{'{5'h19, 8'h95, 8'h95}, '{5'h1A, 8'h17, 8'h17},
		'{5'h1B, 8'h7F, 8'h7F}, '{5'h1C, 8'h40, 8'h40}, '{5'h1D, 8'h01, 8'h01},
		'{5'h18, 8'hFF, 8'h00}, '{5'h1E, 8'hAA, 8'h00}};
	lcs_chan_row_s chans [8] = '{'{8'h85, 8'h97, 5'h05, 7'h65}, '{8'h85, 8'h97, 5'h17, 7'h13},
		'{8'h85, 8'h97, 5'h00, 7'h70}, '{8'h85, 8'h97, 5'h06, 7'h39},
		'{8'h05, 8'h80, 5'h05, 7'h60}, '{8'h05, 8'h80, 5'h00, 7'h13},
		'{8'h80, 8'h80, 5'h00, 7'h5E}, '{8'h98, 8'h98, 5'h18, 7'h70}};

	lcs_bank dut (.clk(clk), .rst(rst), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.pulse_override_enable(pulse_override_enable), .frame_channel(frame_channel),
		.bit_valid(bit_valid), .mark_start(mark_start), .serial_payload_in(serial_payload_in),
		.line_rx_bit(line_rx_bit), .link_controller_b_tx(b_tx), .link_controller_c_tx(c_tx),
		.line_tx_bit(line_tx_bit), .link_controller_b_rx(b_rx),
		.link_controller_b_rx_strobe(b_rxs), .link_controller_b_tx_strobe(b_txs),
		.link_controller_c_rx(c_rx), .link_controller_c_rx_strobe(c_rxs),
		.link_controller_c_tx_strobe(c_txs), .line_driver_outputs(level), .pulse_sign(sign),
		.pulse_magnitude(mag));

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The whole run needs under two hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			conclude();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [4:0] a, input lcs_byte_t d);
		@(posedge clk);
		reg_cs <= 1'h1;
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_cs <= 1'h0;
		reg_wr <= 1'h0;
	endtask

	task rd(input logic [4:0] a, input lcs_byte_t e);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1;
		chk(16'(reg_rdata), 16'(e));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task chan(input lcs_chan_row_s r);
		wr(5'h19, r.bs);
		wr(5'h1A, r.cs);
		@(posedge clk);
		frame_channel <= r.ch;
		bit_valid <= 1'h1;
		{line_rx_bit, b_tx, c_tx, serial_payload_in} <= r.f[6:3];
		@(posedge clk);
		bit_valid <= 1'h0;
		#1;
		chk(16'({b_rxs, b_txs}), 16'({r.f[2], r.f[2]}));
		chk(16'({c_rxs, c_txs}), 16'({r.f[1], r.f[1]}));
		if (r.f[2]) chk(16'(b_rx), 16'(r.f[6]));
		if (r.f[1]) chk(16'(c_rx), 16'(r.f[6]));
		@(posedge clk);
		#1;
		chk(16'(line_tx_bit), 16'(r.f[0]));
		chk(16'({b_rxs, c_rxs}), 16'h0000);
	endtask

	function automatic lcs_level_t lvl(input logic ovr, input int i);
		return ovr ? pw[i] : 7'h40;
	endfunction

	task pchk(input lcs_level_t e);
		chk(16'({level, sign, mag}), 16'({e, e}));
	endtask

	// Retrigger 1 lands in phase one and must be ignored; 2 lands in phase three
	task mark(input logic ovr, input logic [1:0] again);
		@(posedge clk);
		pulse_override_enable <= ovr;
		@(posedge clk);
		mark_start <= 1'h1;
		@(posedge clk);
		mark_start <= (again == 2'h1);
		#1;
		pchk(lvl(ovr, 1));
		@(posedge clk);
		mark_start <= 1'h0;
		#1;
		pchk(lvl(ovr, 2));
		@(posedge clk);
		mark_start <= (again == 2'h2);
		#1;
		pchk(lvl(ovr, 3));
		@(posedge clk);
		mark_start <= 1'h0;
		#1;
		if (again == 2'h2) pchk(lvl(ovr, 1));
		else pchk(7'h00);
		repeat (3) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'h1;
		{reg_cs, reg_wr, reg_addr, reg_wdata, pulse_override_enable, frame_channel} = '0;
		{bit_valid, mark_start, serial_payload_in, line_rx_bit, b_tx, c_tx} = '0;
		repeat (19) @(posedge clk);
		#1;
		chk(16'({reg_rdata, line_tx_bit, level}), 16'h0000);
		@(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			rd(5'h19 + i[4:0], 8'h00);
		end
		$display("reset test done");
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			rd(regs[i].a, regs[i].e);
		end
		$display("register table test done");
		foreach (chans[i]) begin
			chan(chans[i]);
		end
		$display("channel table test done");
		pw = '{7'h45, 7'h3F, 7'h12};
		for (int i = 1; i < 4; i++) begin
			wr(5'h1A + i[4:0], {1'h0, pw[i]});
		end
		mark(1'h1, 2'h0);
		mark(1'h1, 2'h1);
		mark(1'h1, 2'h2);
		mark(1'h0, 2'h0);
		$display("pulse mark test done");
		// A reset in mid-run must detach both controllers and clear every word
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		#1;
		chk(16'({reg_rdata, line_tx_bit, level}), 16'h0000);
		chk(16'({b_rxs, b_txs, c_rxs, c_txs}), 16'h0000);
		@(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			rd(5'h19 + i[4:0], 8'h00);
		end
		$display("mid-run reset test done");
		conclude();
	end
endmodule
